// ==== verification/npc_codec_assertions.sv ====
// Checker for the navigation packet field codec ports
`timescale 1ns/1ns
`default_nettype none
module npc_codec_chk (
	// Clock and control
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic send_dyn,
	input wire logic send_ref,
	input wire logic send_mag,
	input wire logic busy,
	// Streams and results
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic [7:0] tx_id_r,
	input wire logic [7:0] tx_len_r,
	input wire logic mag_new_r,
	input wire logic ext_heading
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	dyn_id_len_a: assert property (send_dyn && !busy && ce |=> tx_id_r == 8'h49 && tx_len_r == 8'h18)
		else $error("dynamics id or length wrong");
	ref_id_len_a: assert property (send_ref && !send_dyn && !busy && ce |=> tx_id_r == 8'h50 && tx_len_r == 8'h2D)
		else $error("reference id or length wrong");
	mag_id_len_a: assert property (send_mag && !send_dyn && !send_ref && !busy && ce
		|=> tx_id_r == 8'h4B && tx_len_r == 8'h11)
		else $error("magnetometer id or length wrong");
	dyn_busy_a: assert property (send_dyn && !busy && ce |=> busy [*8])
		else $error("busy dropped during dynamics payload");
	tx_hold_a: assert property (ce && tx_valid && !tx_ready ##1 ce
		|-> tx_valid && $stable(tx_data))
		else $error("payload byte changed while stalled");
	mag_pulse_a: assert property (mag_new_r && ce |=> !mag_new_r)
		else $error("magnetometer commit pulse too long");
	ext_rise_a: assert property ($rose(ext_heading) |-> $past(mag_new_r))
		else $error("external heading without a packet");
	ext_hold_a: assert property (mag_new_r && ce |=> ext_heading [*8])
		else $error("external heading not held");
endmodule // npc_codec_chk
bind npc_codec npc_codec_chk u_chk (.sys_clk(sys_clk), .srst(srst), .ce(ce), .send_dyn(send_dyn),
	.send_ref(send_ref), .send_mag(send_mag), .busy(busy), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_data(tx_data), .tx_id_r(tx_id_r), .tx_len_r(tx_len_r),
	.mag_new_r(mag_new_r), .ext_heading(ext_heading));
`default_nettype wire

// ==== verification/npc_codec_tb_top.sv ====
// Testbench for the navigation packet field codec
`timescale 1ns/1ns
`default_nettype none
module npc_codec_tb_top;
	logic sys_clk = 0, srst = 1, hok = 0, sd = 0, sr = 0, sm = 0, en = 1;
	logic [31:0] sp = 0;
	logic [159:0] dy = {32'h44332211, 32'h88776655, 32'hCCBBAA99, 32'h3F800000, 32'h01020304};
	// Distinct words so a swapped field shows up
	logic [351:0] rf = {32'hB0B1B2B3, 32'hA0A1A2A3, 32'h90919293, 64'h8081828384858687,
		64'h7071727374757677, 64'h6061626364656667, 32'h50515253, 32'h40414243};
	logic [2:0] fx = 0;
	logic [135:0] mv = {8'hFE, 128'h0123456789ABCDEFFEDCBA9876543210};
	wire tv, tr, rs, rv, mn, mf, mo, eh, bz;
	wire [7:0] td, ti, tl, rid, rd;
	wire [31:0] md, mx, my, mz;
	int err_total = 0, cmp_count = 0, cyc = 0;
	initial forever #10 sys_clk = ~sys_clk;
	npc_codec #(.EXT_HOLD(16'h0010)) dut (.sys_clk(sys_clk), .srst(srst), .ce(en),
		.odo_dist(dy[31:0]), .slip_ang(dy[63:32]), .vel_x(dy[95:64]), .vel_y(dy[127:96]),
		.dist_dev(dy[159:128]), .speed_mag(sp), .heading_ok(hok), .ref_sec(rf[31:0]),
		.ref_usec(rf[63:32]), .ref_lat(rf[127:64]), .ref_lon(rf[191:128]), .ref_alt(rf[255:192]),
		.ref_n(rf[287:256]), .ref_e(rf[319:288]), .ref_d(rf[351:320]), .ref_fix(fx),
		.send_dyn(sd), .send_ref(sr), .send_mag(sm), .busy(bz), .tx_valid(tv), .tx_ready(tr),
		.tx_data(td), .tx_id_r(ti), .tx_len_r(tl), .rx_start(rs), .rx_id(rid), .rx_valid(rv),
		.rx_data(rd), .mag_delay_r(md), .mag_x_r(mx), .mag_y_r(my), .mag_z_r(mz),
		.mag_fail_r(mf), .mag_ovr_r(mo), .mag_new_r(mn), .ext_heading(eh));
	npc_host_model h (.sys_clk(sys_clk), .tx_valid(tv), .tx_ready(tr), .tx_data(td),
		.rx_start(rs), .rx_id(rid), .rx_valid(rv), .rx_data(rd));
	// Compare and count
	task automatic chk(input logic [359:0] g, input logic [359:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Pulse send requests {dyn, ref, mag} for one cycle
	task automatic go(input logic [2:0] s);
		@(posedge sys_clk) #1 {sd, sr, sm} = s;
		@(posedge sys_clk) #1 {sd, sr, sm} = 3'b000;
	endtask
	// Collect n payload bytes, bounded wait
	task automatic pull(input int n, output logic [359:0] v);
		v = 0;
		for (int i = 0; i < 400 && h.q.size() < n; i++)
			@(posedge sys_clk);
		for (int i = 0; i < n; i++)
			v[8*i+:8] = h.q.size() ? h.q.pop_front() : 8'hXX;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_dyn(input logic [31:0] s, input logic k, input logic ok);
		logic [359:0] v;
		sp = s;
		hok = k;
		go(3'b100);
		pull(24, v);
		chk(v, {168'h0, 32'h0, dy[159:64], ok ? dy[63:32] : 32'h0, dy[31:0]});
		chk({ti, tl}, 16'h4918);
	endtask
	// All three requests at once: dynamics wins; enable low freezes the stream
	task automatic t_stall;
		logic [359:0] v;
		sp = 32'h405CCCCE;
		hok = 1;
		go(3'b111);
		repeat (3) @(posedge sys_clk);
		#1 en = 0;
		repeat (4)
		begin
			@(posedge sys_clk) #1;
			chk({tv, bz}, 2'b01);
		end
		en = 1;
		pull(24, v);
		chk(v, {168'h0, 32'h0, dy});
		chk({ti, tl}, 16'h4918);
	endtask
	task automatic t_ref(input logic [2:0] f);
		logic [359:0] v;
		fx = f;
		go(3'b010);
		pull(45, v);
		chk(v, {5'h0, f, rf});
		chk({ti, tl}, 16'h502D);
	endtask
	// Wrong id and short packet must not commit; full one must
	task automatic t_mag;
		logic [359:0] v;
		h.send(8'h49, mv, 17);
		h.send(8'h4B, mv, 10);
		chk(mx, 32'h0);
		h.send(8'h4B, mv, 17);
		chk(mn, 1'b1);
		@(posedge sys_clk) #1;
		chk({mo, mf, mz, my, mx, md}, {2'b10, mv[127:0]});
		chk(eh, 1'b1);
		go(3'b001);
		pull(17, v);
		chk(v, {8'h02, mv[127:0]});
		repeat (20) @(posedge sys_clk) #1;
		chk(eh, 1'b0);
	endtask
	task automatic complete_run;
		$display("Compares %0d, errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Cycle ceiling against hangs
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			complete_run;
		end
	end
	initial
	begin
		repeat (16) @(posedge sys_clk);
		#1 srst = 0;
		t_dyn(32'h405CCCCE, 1, 1);
		t_dyn(32'h405CCCCD, 1, 0);
		t_dyn(32'h405CCCCE, 0, 0);
		t_dyn(32'hC0A00000, 1, 0);
		t_stall;
		for (int f = 0; f < 8; f++)
			t_ref(f[2:0]);
		t_mag;
		complete_run;
	end
endmodule // npc_codec_tb_top
`default_nettype wire

// ==== verification/npc_host_model.sv ====
// Host side model: stalling payload sink and packet sender
`timescale 1ns/1ns
`default_nettype none
module npc_host_model (
	input wire logic sys_clk,
	input wire logic tx_valid,
	output logic tx_ready = 0,
	input wire logic [7:0] tx_data,
	output logic rx_start = 0,
	output logic [7:0] rx_id = 0,
	output logic rx_valid = 0,
	output logic [7:0] rx_data = 0
);
	logic [7:0] q [$]; // Received payload bytes
	int n = 0;
	// Stall one cycle in three to exercise the FIFO
	always @(posedge sys_clk)
	begin
		if (tx_valid && tx_ready)
			q.push_back(tx_data);
		n <= n + 1;
		tx_ready <= #1 (n % 3 != 0);
	end
	// Send nb bytes, LSB first; data is scrambled once released
	task automatic send(input logic [7:0] id, input logic [135:0] v, input int nb);
		@(posedge sys_clk) #1 rx_start = 1;
		rx_id = id;
		for (int i = 0; i < nb; i++)
		begin
			@(posedge sys_clk) #1 rx_start = 0;
			rx_valid = 1;
			rx_data = v[8*i+:8];
		end
		@(posedge sys_clk) #1 rx_valid = 0;
		rx_data = ~rx_data;
	endtask
endmodule // npc_host_model
`default_nettype wire

// ==== verilog/npc_codec.v ====
// Navigation packet field codec: forms three packet payloads and parses the magnetometer one
// Behaviour
// [R01] Dynamics report: id 73, 24 bytes, read-only
// [R02] Slip zero unless heading valid, speed over 3.45
// [R03] Six dynamics words; last reserved word zero
// [R04] Magnetometer packet: id 75, 17 bytes, fields
// [R05] Flag bit0 failure, bit1 over-range
// [R06] External heading flag while magnetometer packets arrive
// [R07] Host supplies already calibrated magnetometer values
// [R08] Host disables internal heading and auto calibration
// [R09] Reference report: id 80, 45 bytes, read-only
// [R10] Reference fields: times, fp64 position, offsets, fix
// [R11] Fix status coded zero to seven
// [R12] Reserved bytes ignored, sent as zero
`timescale 1ns/1ns
`default_nettype none
`include "npc_regs.vh"
module npc_codec #(
	parameter FIFO_D = 32,
	parameter FIFO_AW = 5,
	parameter [15:0] EXT_HOLD = 16'hFFFF
) (
	// Clock, reset, enable
	input wire sys_clk,
	input wire srst,
	input wire ce,
	// Dynamics values
	input wire [31:0] odo_dist,
	input wire [31:0] slip_ang,
	input wire [31:0] vel_x,
	input wire [31:0] vel_y,
	input wire [31:0] dist_dev,
	input wire [31:0] speed_mag,
	input wire heading_ok,
	// Reference station values
	input wire [31:0] ref_sec,
	input wire [31:0] ref_usec,
	input wire [63:0] ref_lat,
	input wire [63:0] ref_lon,
	input wire [63:0] ref_alt,
	input wire [31:0] ref_n,
	input wire [31:0] ref_e,
	input wire [31:0] ref_d,
	input wire [2:0] ref_fix,
	// Send requests
	input wire send_dyn,
	input wire send_ref,
	input wire send_mag,
	output wire busy,
	// Outgoing payload stream
	output wire tx_valid,
	input wire tx_ready,
	output wire [7:0] tx_data,
	output reg [7:0] tx_id_r,
	output reg [7:0] tx_len_r,
	// Incoming payload stream
	input wire rx_start,
	input wire [7:0] rx_id,
	input wire rx_valid,
	input wire [7:0] rx_data,
	// Parsed magnetometer data
	output reg [31:0] mag_delay_r,
	output reg [31:0] mag_x_r,
	output reg [31:0] mag_y_r,
	output reg [31:0] mag_z_r,
	output reg mag_fail_r,
	output reg mag_ovr_r,
	output reg mag_new_r,
	output wire ext_heading
);
	// One-hot send states
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_DYN = 4'h2;
	localparam [3:0] S_REF = 4'h4;
	localparam [3:0] S_MAG = 4'h8;
	reg [3:0] st_r;
	reg [3:0] st_nxt;
	reg [7:0] idx_r; // Byte index within payload
	reg [367:0] shot_r; // Snapshot of payload, byte 0 lowest
	reg [7:0] rx_idx_r; // Receive byte index
	reg rx_mag_r; // Receiving a magnetometer packet
	reg [127:0] rx_buf_r; // Incoming four fields
	reg [15:0] ext_cnt_r; // Hold timer for external heading
	wire f_ready;
	// Byte pick from snapshot
	function [7:0] pick;
		input [367:0] v;
		input [7:0] i;
		begin
			pick = v[i*8 +: 8];
		end
	endfunction
	// Unsigned fp32 magnitude compare; negatives never pass
	function gt_fp;
		input [31:0] a;
		input [31:0] b;
		begin
			gt_fp = !a[31] && (a[30:0] > b[30:0]);
		end
	endfunction
	wire slip_gate = heading_ok && gt_fp(speed_mag, `NPC_SLIP_MIN_FP32); // [R02]
	wire [31:0] slip_out = slip_gate ? slip_ang : 32'h00000000; // [R02]
	wire push = (st_r != S_IDLE) && f_ready;
	wire last = (idx_r == tx_len_r - 8'h01);
	assign busy = (st_r != S_IDLE);
	// Magnetometer readback bytes, flags only in low bits
	wire [7:0] mag_flag_b = {6'h00, mag_ovr_r, mag_fail_r}; // [R05] [R12]
	// Next send state
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE:
			begin
				if (send_dyn)
					st_nxt = S_DYN;
				else if (send_ref)
					st_nxt = S_REF;
				else if (send_mag)
					st_nxt = S_MAG;
			end
			S_DYN, S_REF, S_MAG:
			begin
				if (push && last)
					st_nxt = S_IDLE;
			end
			default:
				st_nxt = S_IDLE;
		endcase
	end
	// Send sequencer: snapshot taken at start so words stay coherent
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			st_r <= S_IDLE;
			idx_r <= 8'h00;
			shot_r <= 368'h0;
			tx_id_r <= 8'h00;
			tx_len_r <= 8'h00;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
			if (st_r == S_IDLE)
			begin
				idx_r <= 8'h00;
				if (send_dyn)
				begin
					tx_id_r <= `NPC_ID_DYN; // [R01]
					tx_len_r <= `NPC_LEN_DYN; // [R01]
					shot_r <= {176'h0, 32'h00000000, dist_dev, vel_y, vel_x,
						slip_out, odo_dist}; // [R03] [R12]
				end
				else if (send_ref)
				begin
					tx_id_r <= `NPC_ID_REF; // [R09]
					tx_len_r <= `NPC_LEN_REF; // [R09]
					// Top byte lies past the payload and is never sent
					shot_r <= {8'h00, 5'h00, ref_fix, ref_d, ref_e, ref_n, ref_alt,
						ref_lon, ref_lat, ref_usec, ref_sec}; // [R10] [R11]
				end
				else if (send_mag)
				begin
					tx_id_r <= `NPC_ID_MAG; // [R04]
					tx_len_r <= `NPC_LEN_MAG; // [R04]
					shot_r <= {232'h0, mag_flag_b, mag_z_r, mag_y_r, mag_x_r,
						mag_delay_r}; // [R04]
				end
			end
			else if (push)
				idx_r <= idx_r + 8'h01;
		end
	end
	// Receive parser; only id 75 is writable, others dropped
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			rx_idx_r <= 8'h00;
			rx_mag_r <= 1'b0;
			rx_buf_r <= 128'h0;
			mag_delay_r <= 32'h00000000;
			mag_x_r <= 32'h00000000;
			mag_y_r <= 32'h00000000;
			mag_z_r <= 32'h00000000;
			mag_fail_r <= 1'b0;
			mag_ovr_r <= 1'b0;
			mag_new_r <= 1'b0;
		end
		else if (ce)
		begin
			mag_new_r <= 1'b0;
			if (rx_start)
			begin
				rx_idx_r <= 8'h00;
				rx_mag_r <= (rx_id == `NPC_ID_MAG); // [R01] [R09]
			end
			else if (rx_valid && rx_mag_r)
			begin
				rx_idx_r <= rx_idx_r + 8'h01;
				if (rx_idx_r < `NPC_MAG_FLAG_OFS)
					rx_buf_r[rx_idx_r[3:0]*8 +: 8] <= rx_data; // [R04]
				else if (rx_idx_r == `NPC_MAG_FLAG_OFS)
				begin
					// Commit whole packet at once; upper flag bits ignored
					mag_delay_r <= rx_buf_r[31:0]; // [R04]
					mag_x_r <= rx_buf_r[63:32];
					mag_y_r <= rx_buf_r[95:64];
					mag_z_r <= rx_buf_r[127:96];
					mag_fail_r <= rx_data[`NPC_MAGF_FAIL]; // [R05]
					mag_ovr_r <= rx_data[`NPC_MAGF_OVR]; // [R05] [R12]
					mag_new_r <= 1'b1;
					rx_mag_r <= 1'b0;
				end
			end
		end
	end
	// External heading held while packets keep arriving
	always @(posedge sys_clk)
	begin
		if (srst)
			ext_cnt_r <= 16'h0000;
		else if (ce)
		begin
			if (mag_new_r)
				ext_cnt_r <= EXT_HOLD; // [R06]
			else if (ext_cnt_r != 16'h0000)
				ext_cnt_r <= ext_cnt_r - 16'h0001;
		end
	end
	assign ext_heading = (ext_cnt_r != 16'h0000); // [R06]
	// Output buffer absorbs host stalls
	npc_fifo #(
		.W(8),
		.D(FIFO_D),
		.AW(FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.in_valid(push),
		.in_ready(f_ready),
		.in_data(pick(shot_r, idx_r)),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);
endmodule // npc_codec
`default_nettype wire

// ==== verilog/npc_fifo.v ====
// Byte FIFO between packet former and transmit port
`timescale 1ns/1ns
`default_nettype none
module npc_fifo #(
	parameter W = 8,
	parameter D = 32,
	parameter AW = 5
) (
	// Clock, reset, enable
	input wire sys_clk,
	input wire srst,
	input wire ce,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	// Storage and pointers, one spare bit for full detect
	reg [W-1:0] mem_r [0:D-1];
	reg [AW:0] wp_r;
	reg [AW:0] rp_r;
	wire [AW:0] cnt = wp_r - rp_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = ce && (cnt != D[AW:0]);
	assign out_valid = ce && (cnt != {(AW+1){1'b0}});
	assign out_data = mem_r[rp_r[AW-1:0]];
	// Pointer update
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			wp_r <= {(AW+1){1'b0}};
			rp_r <= {(AW+1){1'b0}};
		end
		else if (ce)
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end
	// Data write, no reset needed on storage
	always @(posedge sys_clk)
	begin
		if (ce && push)
			mem_r[wp_r[AW-1:0]] <= in_data;
	end
endmodule // npc_fifo
`default_nettype wire

// ==== verilog/npc_regs.vh ====
// Constants for the navigation packet field codec
`ifndef NPC_REGS_VH
`define NPC_REGS_VH
// Packet identifiers and payload lengths
`define NPC_ID_DYN 8'h49
`define NPC_LEN_DYN 8'h18
`define NPC_ID_MAG 8'h4B
`define NPC_LEN_MAG 8'h11
`define NPC_ID_REF 8'h50
`define NPC_LEN_REF 8'h2D
// Slip gate threshold 3.45 m/s as fp32 bit pattern
`define NPC_SLIP_MIN_FP32 32'h405CCCCD
// Magnetometer flag bit positions
`define NPC_MAGF_FAIL 0
`define NPC_MAGF_OVR 1
// Offset of the magnetometer flag byte
`define NPC_MAG_FLAG_OFS 8'h10
// Fix status codes
`define NPC_FIX_NONE 3'h0
`define NPC_FIX_2D 3'h1
`define NPC_FIX_3D 3'h2
`define NPC_FIX_SBAS 3'h3
`define NPC_FIX_DIFF 3'h4
`define NPC_FIX_SUBS 3'h5
`define NPC_FIX_FLOAT 3'h6
`define NPC_FIX_FIXED 3'h7
// Fix status field width
`define NPC_FIX_W 3
`endif
